// >>> verilog/adcs_regs.vh
// How it works
// [R01] Control write with start bit one launches a sequence; zero does nothing.
// [R02] Trigger enable low: hardware trigger ignored, software start only.
// [R03] Trigger enable high: selected hardware trigger starts a sequence.
// [R04] Trigger select 110 picks the external trigger; other codes are reserved.
// [R05] Resolution bit zero gives 10-bit results, one gives 8-bit results.
// [R06] Converter clock is master clock divided by two times (prescaler plus one).
// [R07] Start-up wait lasts eight converter periods times (start-up field plus one).
// [R08] Sample-and-hold lasts sample-hold field plus one converter periods.
// [R09] Channel-enable write: each one bit enables its channel, zeros unchanged.
// [R10] Channel-disable write: each one bit disables its channel, zeros unchanged.
// [R11] Software must not disable or re-enable a channel during a conversion.
// [R12] Channel status bits read one for enabled channels, zero for disabled.
// [R13] Status bits 0-7 show channel enabled and its conversion complete.
// [R14] Status bits 8-15 flag per-channel overrun; status read clears them.
// [R15] Status bit 16 sets on any result, clears on latest-result read.
// [R16] Status bit 17 flags general overrun; status read clears it.
// [R17] Status bit 18 sets at receive count zero, clears on counter write.
// [R18] Status bit 19 reads one exactly when both DMA counters are zero.
// [R19] Latest-result bits 9-0 load at each conversion end and hold.
// [R20] Interrupt-enable register uses the status bit layout, one enable per flag.
// [R21] Sleep mode: power up on start, wait start-up, convert, power down.
// [R22] Triggers during a running sequence are ignored.
// [R23] Software start still works while a hardware trigger is selected.
// [R24] Soft-reset bit one returns the whole block to its reset state.
// [R25] Interrupt output is high while any enabled status flag is set.
// [R26] Done with result flag set gives general overrun; done with channel flag set gives channel overrun.
// [R27] A channel's done flag clears when its own result register is read.
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH
`define ADCS_OFF_CTRL 8'h00
`define ADCS_OFF_MODE 8'h04
`define ADCS_OFF_CHSET 8'h10
`define ADCS_OFF_CHCLR 8'h14
`define ADCS_OFF_CHSTAT 8'h18
`define ADCS_OFF_FLAGS 8'h1c
`define ADCS_OFF_LATEST 8'h20
`define ADCS_OFF_IRQSET 8'h24
`define ADCS_OFF_IRQCLR 8'h28
`define ADCS_OFF_IRQMASK 8'h2c
`define ADCS_OFF_CDR_BASE 8'h30
`define ADCS_OFF_CDR_LAST 8'h4c
`define ADCS_CTRL_SOFT_RESET 0
`define ADCS_CTRL_START 1
`define ADCS_MODE_HW_TRIG 0
`define ADCS_MODE_TRIG_SEL 3:1
`define ADCS_MODE_REDUCED 4
`define ADCS_MODE_SLEEP 5
`define ADCS_MODE_PRESC 13:8
`define ADCS_MODE_STARTUP 20:16
`define ADCS_MODE_SAMPLE_HOLD 27:24
`define ADCS_MODE_MASK 32'h0f1f3f3f
`define ADCS_TRG_EXTERNAL 3'h6
`define ADCS_FLAG_DONE 7:0
`define ADCS_FLAG_CH_OVERRUN 15:8
`define ADCS_FLAG_AVAIL 16
`define ADCS_FLAG_GLOBAL_OVERRUN 17
`define ADCS_FLAG_DMA_DONE 18
`define ADCS_FLAG_DMA_FULL 19
`define ADCS_FLAG_MASK 32'h000fffff
`define ADCS_DMA_DONE_RST 1'b1
`define ADCS_STARTUP_LOW 3'h7
`define ADCS_CH_NONE 4'h8
`define ADCS_CH_FIRST 4'h0
`define ADCS_CH_STEP 4'h1
`define ADCS_REDUCED_MASK 10'h0ff
`define ADCS_FULLRES_MASK 10'h3ff
`endif

// >>> verilog/adcs_top.v
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "adcs_regs.vh"
module adcs_top (
  // Clock, reset, freeze
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Trigger
  input wire ext_trigger_i,
  // Analog cell
  output reg adc_clk_o,
  output reg power_on_o,
  output reg sampling_o,
  output reg conv_start_o,
  output reg [2:0] conv_channel_o,
  output reg conv_reduced_o,
  input wire conv_done_i,
  input wire [9:0] conv_data_i,
  // DMA channel
  input wire dma_count_reached_i,
  input wire dma_count_write_i,
  input wire dma_count_zero_i,
  input wire dma_next_count_zero_i,
  output reg dma_req_o,
  // Interrupt
  output wire irq_o
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_STARTUP = 5'h02;
  localparam [4:0] ST_SAMPLE = 5'h04;
  localparam [4:0] ST_CONVERT = 5'h08;

  reg soft_reset_r;
  reg [31:0] mode_r;
  reg [7:0] chen_r;
  reg [7:0] done_flag_r;
  reg [7:0] ch_overrun_r;
  reg avail_r;
  reg global_overrun_r;
  reg dma_done_r;
  reg [19:0] imr_r;
  reg [9:0] latest_r;
  reg [9:0] cdr_r [0:7];
  reg [4:0] state_r;
  reg [5:0] div_r;
  reg [8:0] wait_r;
  reg [3:0] cur_r;
  reg warm_r;
  reg trig_d_r;
  reg [4:0] state_nxt;
  reg [3:0] ch_nxt;
  reg [31:0] rd_nxt;
  integer i;

  wire rst = srst_i | soft_reset_r;
  wire wr_ctrl = wr_i && (addr_i == `ADCS_OFF_CTRL);
  wire rd_flags = rd_i && (addr_i == `ADCS_OFF_FLAGS);
  wire rd_latest = rd_i && (addr_i == `ADCS_OFF_LATEST);
  wire rd_cdr = rd_i && (addr_i >= `ADCS_OFF_CDR_BASE) && (addr_i <= `ADCS_OFF_CDR_LAST);
  wire [7:0] cdr_off = addr_i - `ADCS_OFF_CDR_BASE;
  wire [2:0] cdr_idx = cdr_off[4:2];
  wire [3:0] done_bit_idx = cur_r;

  // One converter period spans both halves of the divided clock
  wire tick = (div_r == mode_r[`ADCS_MODE_PRESC]) && adc_clk_o; // see [R06]
  wire trig_edge = ext_trigger_i && !trig_d_r;
  wire hw_start = mode_r[`ADCS_MODE_HW_TRIG] && (mode_r[`ADCS_MODE_TRIG_SEL] == `ADCS_TRG_EXTERNAL) && trig_edge; // see [R02] [R03] [R04]
  wire sw_start = wr_ctrl && wdata_i[`ADCS_CTRL_START]; // see [R01]
  wire start_req = sw_start || hw_start; // see [R23]
  wire done = (state_r == ST_CONVERT) && conv_done_i;
  wire [9:0] res_mask = mode_r[`ADCS_MODE_REDUCED] ? `ADCS_REDUCED_MASK : `ADCS_FULLRES_MASK; // see [R05]
  wire [9:0] result = conv_data_i & res_mask;
  wire dma_full = dma_count_zero_i && dma_next_count_zero_i; // see [R18]
  wire [19:0] flags = {dma_full, dma_done_r, global_overrun_r, avail_r, ch_overrun_r, done_flag_r & chen_r}; // see [R13]

  assign irq_o = |(flags & imr_r); // see [R25]

  function [3:0] next_ch;
    input [7:0] en;
    input [3:0] from;
    integer k;
    begin
      next_ch = `ADCS_CH_NONE;
      for (k = 7; k >= 0; k = k - 1)
      begin
        if (en[k] && (k >= from))
          next_ch = k[3:0];
      end
    end
  endfunction

  // Soft reset acts one cycle after the write and drops again on the next enabled cycle without such a write
  always @(posedge clk_i)
  begin
    if (srst_i)
      soft_reset_r <= 1'b0;
    else if (ce_i)
      soft_reset_r <= wr_ctrl && wdata_i[`ADCS_CTRL_SOFT_RESET]; // see [R24]
  end

  always @*
  begin
    state_nxt = state_r;
    ch_nxt = next_ch(chen_r, cur_r + `ADCS_CH_STEP);
    case (state_r)
      ST_IDLE:
      begin
        // Starts while busy fall outside this state and are dropped
        if (start_req && (|chen_r)) // see [R22]
          state_nxt = (mode_r[`ADCS_MODE_SLEEP] || !warm_r) ? ST_STARTUP : ST_SAMPLE; // see [R21]
      end
      ST_STARTUP:
      begin
        if (tick && (wait_r == {1'b0, mode_r[`ADCS_MODE_STARTUP], `ADCS_STARTUP_LOW})) // see [R07]
          state_nxt = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        if (tick && (wait_r == {5'h00, mode_r[`ADCS_MODE_SAMPLE_HOLD]})) // see [R08]
          state_nxt = ST_CONVERT;
      end
      ST_CONVERT:
      begin
        if (conv_done_i)
          state_nxt = (ch_nxt == `ADCS_CH_NONE) ? ST_IDLE : ST_SAMPLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      div_r <= 6'h00;
      adc_clk_o <= 1'b0;
      wait_r <= 9'h000;
      cur_r <= `ADCS_CH_FIRST;
      warm_r <= 1'b0;
      trig_d_r <= 1'b0;
      power_on_o <= 1'b0;
      sampling_o <= 1'b0;
      conv_start_o <= 1'b0;
      conv_channel_o <= 3'h0;
      conv_reduced_o <= 1'b0;
      dma_req_o <= 1'b0;
    end
    else if (ce_i)
    begin
      trig_d_r <= ext_trigger_i;
      if (div_r == mode_r[`ADCS_MODE_PRESC])
      begin
        div_r <= 6'h00;
        adc_clk_o <= !adc_clk_o; // see [R06]
      end
      else
        div_r <= div_r + 6'h01;
      conv_start_o <= 1'b0;
      dma_req_o <= done;
      state_r <= state_nxt;
      if (state_r != state_nxt)
        wait_r <= 9'h000;
      else if (tick)
        wait_r <= wait_r + 9'h001;
      case (state_r)
        ST_IDLE:
        begin
          // Normal mode keeps the cell warm, sleep mode only powers it for a sequence
          power_on_o <= !mode_r[`ADCS_MODE_SLEEP] && warm_r;
          if (mode_r[`ADCS_MODE_SLEEP])
            warm_r <= 1'b0;
          if (state_nxt != ST_IDLE)
          begin
            power_on_o <= 1'b1; // see [R21]
            cur_r <= next_ch(chen_r, `ADCS_CH_FIRST);
          end
        end
        ST_STARTUP:
        begin
          if (state_nxt == ST_SAMPLE)
            warm_r <= 1'b1;
        end
        ST_SAMPLE:
        begin
          sampling_o <= 1'b1;
          conv_channel_o <= cur_r[2:0];
          if (state_nxt == ST_CONVERT)
          begin
            sampling_o <= 1'b0;
            conv_start_o <= 1'b1;
            conv_reduced_o <= mode_r[`ADCS_MODE_REDUCED];
          end
        end
        ST_CONVERT:
        begin
          if (conv_done_i && (ch_nxt != `ADCS_CH_NONE))
            cur_r <= ch_nxt;
          if (conv_done_i && (ch_nxt == `ADCS_CH_NONE) && mode_r[`ADCS_MODE_SLEEP])
            power_on_o <= 1'b0; // see [R21]
        end
        default:
          sampling_o <= 1'b0;
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (rst)
    begin
      mode_r <= 32'h00000000;
      chen_r <= 8'h00;
      imr_r <= 20'h00000;
    end
    else if (ce_i && wr_i)
    begin
      if (addr_i == `ADCS_OFF_MODE)
        mode_r <= wdata_i & `ADCS_MODE_MASK;
      else if (addr_i == `ADCS_OFF_CHSET)
        chen_r <= chen_r | wdata_i[7:0]; // see [R09]
      else if (addr_i == `ADCS_OFF_CHCLR)
        chen_r <= chen_r & ~wdata_i[7:0]; // see [R10]
      else if (addr_i == `ADCS_OFF_IRQSET)
        imr_r <= imr_r | wdata_i[19:0]; // see [R20]
      else if (addr_i == `ADCS_OFF_IRQCLR)
        imr_r <= imr_r & ~wdata_i[19:0];
    end
  end

  // Flags: in every case a hardware set in the same cycle as a clear wins
  always @(posedge clk_i)
  begin
    if (rst)
    begin
      done_flag_r <= 8'h00;
      ch_overrun_r <= 8'h00;
      avail_r <= 1'b0;
      global_overrun_r <= 1'b0;
      dma_done_r <= `ADCS_DMA_DONE_RST;
      latest_r <= 10'h000;
      for (i = 0; i < 8; i = i + 1)
        cdr_r[i] <= 10'h000;
    end
    else if (ce_i)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        if (done && (done_bit_idx == i) && chen_r[i])
        begin
          done_flag_r[i] <= 1'b1;
          cdr_r[i] <= result;
          if (done_flag_r[i])
            ch_overrun_r[i] <= 1'b1; // see [R26]
          else if (rd_flags)
            ch_overrun_r[i] <= 1'b0; // see [R14]
        end
        else
        begin
          if (rd_cdr && (cdr_idx == i))
            done_flag_r[i] <= 1'b0; // see [R27]
          if (rd_flags)
            ch_overrun_r[i] <= 1'b0; // see [R14]
        end
      end
      if (done)
      begin
        latest_r <= result; // see [R19]
        avail_r <= 1'b1; // see [R15]
      end
      else if (rd_latest)
        avail_r <= 1'b0; // see [R15]
      if (done && avail_r)
        global_overrun_r <= 1'b1; // see [R26]
      else if (rd_flags)
        global_overrun_r <= 1'b0; // see [R16]
      if (dma_count_reached_i)
        dma_done_r <= 1'b1; // see [R17]
      else if (dma_count_write_i)
        dma_done_r <= 1'b0; // see [R17]
    end
  end

  always @*
  begin
    rd_nxt = 32'h00000000;
    if (addr_i == `ADCS_OFF_MODE)
      rd_nxt = mode_r;
    else if (addr_i == `ADCS_OFF_CHSTAT)
      rd_nxt = {24'h000000, chen_r}; // see [R12]
    else if (addr_i == `ADCS_OFF_FLAGS)
      rd_nxt = {12'h000, flags};
    else if (addr_i == `ADCS_OFF_LATEST)
      rd_nxt = {22'h000000, latest_r};
    else if (addr_i == `ADCS_OFF_IRQMASK)
      rd_nxt = {12'h000, imr_r};
    else if (rd_cdr)
      rd_nxt = {22'h000000, cdr_r[cdr_idx]};
  end

  always @(posedge clk_i)
  begin
    if (rst)
      rdata_o <= 32'h00000000;
    else if (ce_i)
      rdata_o <= rd_i ? rd_nxt : 32'h00000000;
  end
endmodule

// >>> tb/adcs_props.sv
`timescale 1ns/100ps
module adcs_props (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // Cell and DMA
  input wire adc_clk_o,
  input wire power_on_o,
  input wire conv_start_o,
  input wire [2:0] conv_channel_o,
  input wire conv_reduced_o,
  input wire sampling_o,
  input wire dma_count_zero_i,
  input wire dma_next_count_zero_i,
  input wire irq_o
);
  reg [31:0] mode_r;
  reg [7:0] en_r;
  reg [7:0] hcnt_r;
  reg [1:0] ntog_r;
  reg ier_r;
  reg srq_r;
  wire wm = wr_i && addr_i == 8'h04;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Soft reset lands one edge after its write; divider phase is trusted only after two clean halves
  always @(posedge clk_i)
  begin
    srq_r <= wr_i && addr_i == 8'h00 && wdata_i[0];
    hcnt_r <= $changed(adc_clk_o) ? 8'h00 : hcnt_r + 8'h01;
    if ($changed(adc_clk_o) && ntog_r != 2'h3)
      ntog_r <= ntog_r + 2'h1;
    if (wm || !power_on_o)
      ntog_r <= 2'h0;
    if (wm)
      mode_r <= wdata_i & 32'h0f1f3f3f;
    if (wr_i && addr_i == 8'h10)
      en_r <= en_r | wdata_i[7:0];
    if (wr_i && addr_i == 8'h14)
      en_r <= en_r & ~wdata_i[7:0];
    if (wr_i && addr_i == 8'h24 && wdata_i[19:0] != 20'h0)
      ier_r <= 1'b1;
    if (wr_i && addr_i == 8'h28 && wdata_i[19:0] == 20'hfffff)
      ier_r <= 1'b0;
    if (srst_i || srq_r)
    begin
      mode_r <= 32'h0;
      en_r <= 8'h0;
      ier_r <= 1'b0;
      ntog_r <= 2'h0;
    end
  end
  chk_clk_half: assert property ($changed(adc_clk_o) && ntog_r >= 2'h2 |-> hcnt_r == {2'h0, mode_r[13:8]})
    else $error("Converter clock half period wrong");
  chk_mode_read: assert property (rd_i && addr_i == 8'h04 |=> rdata_o == $past(mode_r))
    else $error("Mode readback wrong");
  chk_chan_state: assert property (rd_i && addr_i == 8'h18 |=> rdata_o == {24'h0, $past(en_r)})
    else $error("Channel state wrong");
  chk_buf_full: assert property (rd_i && addr_i == 8'h1c |=> rdata_o[19] == $past(dma_count_zero_i && dma_next_count_zero_i))
    else $error("Buffers full flag wrong");
  chk_irq_quiet: assert property (!ier_r |-> !irq_o)
    else $error("Interrupt without enable");
  chk_res_mode: assert property (conv_start_o |-> conv_reduced_o == mode_r[4])
    else $error("Resolution wrong");
  chk_chan_on: assert property (conv_start_o |-> en_r[conv_channel_o])
    else $error("Disabled channel converted");
  chk_conv_power: assert property (conv_start_o |-> power_on_o && $past(power_on_o))
    else $error("Conversion while unpowered");
  chk_sample_end: assert property (conv_start_o |-> !sampling_o && $past(sampling_o))
    else $error("Conversion started without sampling");
  cover property (conv_start_o);
  cover property ($fell(power_on_o));
  cover property (irq_o);
endmodule

// >>> tb/adcs_cell_model.sv
`timescale 1ns/100ps
module adcs_cell_model (
  // Clock
  input wire clk_i,
  // Block side
  input wire start_i,
  input wire [2:0] ch_i,
  input wire [9:0] base_i,
  output reg done_o,
  output reg [9:0] data_o
);
  reg [3:0] cnt_r = 4'h0;
  reg slow_r = 1'b0;
  reg [2:0] ch_r = 3'h0;
  initial done_o = 1'b0;
  initial data_o = 10'h0;
  // Prompt and slow answers alternate; data flips when not valid so stale values never match
  always @(posedge clk_i)
  begin
    done_o <= cnt_r == 4'h1;
    data_o <= cnt_r == 4'h1 ? base_i ^ {7'h0, ch_r} : ~data_o;
    if (start_i)
    begin
      cnt_r <= slow_r ? 4'h9 : 4'h2;
      slow_r <= ~slow_r;
      ch_r <= ch_i;
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule

// >>> tb/adc_control_and_status_tb_top.sv
`timescale 1ns/100ps
module adc_control_and_status_tb_top;
  reg clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg ce_i = 1'b1;
  reg [7:0] addr_i = 8'h00;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg ext_trigger_i = 1'b0;
  reg dma_count_reached_i = 1'b0;
  reg dma_count_write_i = 1'b0;
  reg dma_count_zero_i = 1'b1;
  reg dma_next_count_zero_i = 1'b1;
  reg [9:0] base_r = 10'h155;
  wire [31:0] rdata_o;
  wire adc_clk_o, power_on_o, sampling_o, conv_start_o, conv_reduced_o, conv_done_i, dma_req_o, irq_o;
  wire [2:0] conv_channel_o;
  wire [9:0] conv_data_i;
  integer err_count = 0;
  integer n_checks = 0;
  integer i;
  reg [31:0] d, v;
  reg [7:0] m, en;
  reg lr, ex;
  adcs_top i_dut (.*);
  adcs_cell_model i_cell (.clk_i(clk_i), .start_i(conv_start_o), .ch_i(conv_channel_o), .base_i(base_r),
    .done_o(conv_done_i), .data_o(conv_data_i));
  initial
    forever #5 clk_i = ~clk_i;
  task close_out;
  begin
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task cmp(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("Error %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] x);
  begin
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= x;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  task rc(input [7:0] a, input [31:0] e);
  begin
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    cmp("rdata", e, rdata_o);
  end
  endtask
  // Counts results over a window long enough for eight slow channels
  task seq(input [31:0] n);
    reg [31:0] c;
  begin
    c = 0;
    repeat (600)
    begin
      @(posedge clk_i);
      #1;
      if (dma_req_o === 1'b1)
        c = c + 1;
    end
    cmp("results", n, c);
  end
  endtask
  function [2:0] hi(input [7:0] x);
    integer k;
  begin
    hi = 3'h0;
    for (k = 0; k < 8; k = k + 1)
      if (x[k])
        hi = k[2:0];
  end
  endfunction
  function [31:0] res(input [2:0] ch);
  begin
    res = {22'h0, (base_r ^ {7'h0, ch}) & (lr ? 10'h0ff : 10'h3ff)};
  end
  endfunction
  function [31:0] fl(input [7:0] ov, input g, input r);
  begin
    fl = {12'h0, dma_count_zero_i & dma_next_count_zero_i, ex, g, r, ov, m};
  end
  endfunction
  initial
  begin
    i = $urandom(32'hf5ca686e);
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    ex = 1'b1;
    m = 8'h0;
    rc(8'h1c, fl(8'h0, 1'b0, 1'b0));
    rc(8'h20, 32'h0);
    v = $urandom;
    wr(8'h04, v);
    rc(8'h04, v & 32'h0f1f3f3f);
    en = 8'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
      d = $urandom;
      v = $urandom;
      wr(8'h10, d);
      wr(8'h14, v);
      en = (en | d[7:0]) & ~v[7:0];
      rc(8'h18, {24'h0, en});
    end
    d = $urandom;
    m = d[7:0] | 8'h01;
    lr = d[8];
    base_r <= d[25:16];
    wr(8'h14, 32'hff);
    wr(8'h10, {24'h0, m});
    wr(8'h04, 32'h01000120 | {27'h0, lr, 4'h0});
    wr(8'h00, 32'h0);
    ext_trigger_i <= 1'b1;
    seq(0);
    ext_trigger_i <= 1'b0;
    // Enables stay untouched while a sequence runs
    wr(8'h04, 32'h0100012d | {27'h0, lr, 4'h0});
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h2);
    seq($countones(m));
    cmp("power", 32'h0, {31'h0, power_on_o});
    // Every result after the first lands while the unread one still waits
    rc(8'h1c, fl(8'h0, ($countones(m) > 1), 1'b1));
    rc(8'h08, 32'h0);
    rc(8'h24, 32'h0);
    wr(8'h24, 32'h10000);
    #1;
    cmp("irq", 32'h1, {31'h0, irq_o});
    rc(8'h2c, 32'h10000);
    wr(8'h28, 32'hfffff);
    #1;
    cmp("irq", 32'h0, {31'h0, irq_o});
    @(posedge clk_i);
    ext_trigger_i <= 1'b1;
    seq($countones(m));
    ext_trigger_i <= 1'b0;
    rc(8'h1c, fl(m, 1'b1, 1'b1));
    rc(8'h1c, fl(8'h0, 1'b0, 1'b1));
    rc(8'h20, res(hi(m)));
    rc(8'h1c, fl(8'h0, 1'b0, 1'b0));
    rc(8'h30 + {3'h0, hi(m), 2'h0}, res(hi(m)));
    m = m & ~(8'h01 << hi(m));
    rc(8'h1c, fl(8'h0, 1'b0, 1'b0));
    @(posedge clk_i);
    dma_count_write_i <= 1'b1;
    dma_count_zero_i <= d[30];
    dma_next_count_zero_i <= d[31];
    @(posedge clk_i);
    dma_count_write_i <= 1'b0;
    ex = 1'b0;
    rc(8'h1c, fl(8'h0, 1'b0, 1'b0));
    @(posedge clk_i);
    dma_count_reached_i <= 1'b1;
    @(posedge clk_i);
    dma_count_reached_i <= 1'b0;
    ex = 1'b1;
    rc(8'h1c, fl(8'h0, 1'b0, 1'b0));
    wr(8'h00, 32'h1);
    m = 8'h0;
    rc(8'h18, 32'h0);
    rc(8'h04, 32'h0);
    rc(8'h1c, fl(8'h0, 1'b0, 1'b0));
    close_out;
  end
endmodule
bind adcs_top adcs_props i_props (.*);
